// ---- rtl/jesd_link_cfg.svh ----
// Register map, field positions, reset values and link constants
`ifndef JESD_LINK_CFG_SVH
`define JESD_LINK_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define REG_CTRL 8'h00
`define REG_KCFG 8'h04
`define REG_DID 8'h08
`define REG_STATUS 8'h0c
`define REG_PARAM_A 8'h10
`define REG_PARAM_B 8'h14
`define LANE_SUM_PAGE 3'h1

// ****************************************
// Field positions and reset values
// ****************************************
`define CTRL_EN_BIT 0
`define CTRL_SCR_BIT 1
`define CTRL_FMT_LSB 8
`define CTRL_FMT_MSB 13
`define FMT_RESET 6'h00
`define KCFG_RESET 8'h1f
`define DID_RESET 8'h00

// ****************************************
// Link constants
// ****************************************
`define FMT_64B_BASE 6'h20
`define ILAS_MF_COUNT 3'h4
`define ILAS_CFG_OCTETS 4'he
`define JESDV_VAL 3'h1
`define SUBCLASSV_VAL 3'h1
`define MB_PER_EMB 8'h01
`define PLL_BYPASS_R_X8 6'h28

`endif

// ---- rtl/jesd_link_pkg.sv ----
// Types shared by the link parameter block
package jesd_link_pkg;

  typedef struct packed {
    logic valid;
    logic enc64;
    logic des;
    logic [4:0] n;
    logic [1:0] cs;
    logic [4:0] np;
    logic [3:0] l;
    logic [3:0] m;
    logic [3:0] f;
    logic [3:0] s;
    logic hd;
    logic [5:0] r_x8;
    logic [5:0] kmin;
    logic [2:0] kstep_lg;
  } fmt_param_t;

  typedef enum logic [1:0] {LINK_OFF, LINK_CGS, LINK_ILAS, LINK_DATA} link_state_t;

endpackage : jesd_link_pkg

// ---- rtl/fmt_table.sv ----
// Format code to transport and link parameter lookup
`timescale 1ns/1ns
`include "jesd_link_cfg.svh"
module fmt_table (
  input wire logic [5:0] fmt,
  output jesd_link_pkg::fmt_param_t p
);
  import jesd_link_pkg::*;

  logic [5:0] idx;
  logic enc64;

  // ****************************************
  // Upper code half reuses the lower parameter set
  // ****************************************
  assign enc64 = (fmt >= `FMT_64B_BASE);
  assign idx = enc64 ? 6'(fmt - `FMT_64B_BASE) : fmt;

  always_comb begin
    p = '0;
    case (idx)
      6'h00: p = '{1'b1, enc64, 1'b1, 5'h0c, 2'h0, 5'h0c, 4'h4, 4'h4, 4'h8, 4'h5, 1'b0, 6'h20, 6'h04, 3'h1};
      6'h01: p = '{1'b1, enc64, 1'b1, 5'h0c, 2'h0, 5'h0c, 4'h8, 4'h8, 4'h8, 4'h5, 1'b0, 6'h10, 6'h04, 3'h1};
      6'h02: p = '{1'b1, enc64, 1'b0, 5'h0c, 2'h0, 5'h0c, 4'h4, 4'h4, 4'h8, 4'h5, 1'b0, 6'h20, 6'h04, 3'h1};
      6'h03: p = '{1'b1, enc64, 1'b0, 5'h0c, 2'h0, 5'h0c, 4'h8, 4'h8, 4'h8, 4'h5, 1'b0, 6'h10, 6'h04, 3'h1};
      6'h05: p = '{1'b1, enc64, 1'b1, 5'h08, 2'h0, 5'h08, 4'h4, 4'h1, 4'h1, 4'h4, 1'b0, 6'h14, 6'h20, 3'h4};
      6'h06: p = '{1'b1, enc64, 1'b1, 5'h08, 2'h0, 5'h08, 4'h8, 4'h1, 4'h1, 4'h8, 1'b0, 6'h0a, 6'h20, 3'h4};
      6'h07: p = '{1'b1, enc64, 1'b0, 5'h08, 2'h0, 5'h08, 4'h4, 4'h1, 4'h1, 4'h4, 1'b0, 6'h14, 6'h20, 3'h4};
      6'h08: p = '{1'b1, enc64, 1'b0, 5'h08, 2'h0, 5'h08, 4'h8, 4'h1, 4'h1, 4'h8, 1'b0, 6'h0a, 6'h20, 3'h4};
      6'h0a: p = '{1'b1, enc64, 1'b0, 5'h0f, 2'h1, 5'h10, 4'h2, 4'h2, 4'h2, 4'h1, 1'b0, 6'h28, 6'h10, 3'h3};
      6'h0b: p = '{1'b1, enc64, 1'b0, 5'h0f, 2'h1, 5'h10, 4'h4, 4'h2, 4'h2, 4'h2, 1'b0, 6'h14, 6'h10, 3'h3};
      6'h0c: p = '{1'b1, enc64, 1'b0, 5'h0f, 2'h1, 5'h10, 4'h8, 4'h2, 4'h2, 4'h4, 1'b0, 6'h0a, 6'h10, 3'h3};
      6'h0d: p = '{1'b1, enc64, 1'b0, 5'h0f, 2'h1, 5'h10, 4'h1, 4'h2, 4'h4, 4'h1, 1'b0, 6'h28, 6'h08, 3'h2};
      6'h0e: p = '{1'b1, enc64, 1'b0, 5'h0f, 2'h1, 5'h10, 4'h2, 4'h2, 4'h2, 4'h1, 1'b0, 6'h14, 6'h10, 3'h3};
      6'h0f: p = '{1'b1, enc64, 1'b0, 5'h0f, 2'h1, 5'h10, 4'h4, 4'h2, 4'h2, 4'h2, 1'b0, 6'h0a, 6'h10, 3'h3};
      6'h10: p = '{1'b1, enc64, 1'b0, 5'h0f, 2'h1, 5'h10, 4'h8, 4'h2, 4'h2, 4'h4, 1'b0, 6'h05, 6'h10, 3'h3};
      6'h13: p = '{1'b1, enc64, 1'b1, 5'h0c, 2'h0, 5'h0c, 4'h6, 4'h1, 4'h2, 4'h8, 1'b1, 6'h14, 6'h10, 3'h3};
      6'h14: p = '{1'b1, enc64, 1'b0, 5'h0c, 2'h0, 5'h0c, 4'h6, 4'h1, 4'h2, 4'h8, 1'b1, 6'h14, 6'h10, 3'h3};
      6'h15: p = '{1'b1, enc64, 1'b1, 5'h0f, 2'h1, 5'h10, 4'h2, 4'h1, 4'h2, 4'h2, 1'b0, 6'h28, 6'h10, 3'h3};
      6'h16: p = '{1'b1, enc64, 1'b1, 5'h0f, 2'h1, 5'h10, 4'h4, 4'h1, 4'h2, 4'h4, 1'b0, 6'h14, 6'h10, 3'h3};
      6'h17: p = '{1'b1, enc64, 1'b1, 5'h0f, 2'h1, 5'h10, 4'h1, 4'h1, 4'h2, 4'h1, 1'b0, 6'h28, 6'h10, 3'h3};
      6'h18: p = '{1'b1, enc64, 1'b1, 5'h0f, 2'h1, 5'h10, 4'h2, 4'h1, 4'h2, 4'h2, 1'b0, 6'h14, 6'h10, 3'h3};
      // Reserved codes leave valid low
      default: p = '0;
    endcase
  end

endmodule : fmt_table

// ---- rtl/ilas_lane_sum.sv ----
// Per-lane identifier and alignment checksum
`timescale 1ns/1ns
module ilas_lane_sum #(
  parameter int LANE_ID = 0
) (
  input wire logic [7:0] base_sum,
  output logic [4:0] lane_id,
  output logic [7:0] lane_sum
);

  localparam logic [4:0] LID = 5'(LANE_ID);

  assign lane_id = LID;
  assign lane_sum = 8'(base_sum + {3'h0, LID});

endmodule : ilas_lane_sum

// ---- rtl/jesd_link_param_ilas_gen.sv ----
// Link parameter derivation, alignment sequence octets and APB registers
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`include "jesd_link_cfg.svh"

// Function
// - Derive link parameters from format code, except frame count, identifier and scrambler flag
// - Interleave flag one single, zero dual
// - Line rate is clock times bits-per-clock
// - Frames per multiframe from field, 8b10b only
// - Multiblocks per extended multiblock fixed one
// - Send all parameters except high-density flag in alignment sequence; control bits go out as zero
// - No alignment sequence in 64b66b mode
// - Fixed zero and one alignment fields
// - Control bits reported as zero in alignment sequence
// - Identifier comes from user field
// - Scrambler flag follows user control
// - Checksum is parameter sum modulo 256
// - Converter count taken from format
// - Report resolution and total sample bits
// - Each lane gets device-assigned identifier
// - Octets per frame from format, reported
// - Samples per frame from format, reported
// - Start sequence on receiver sync request
module jesd_link_param_ilas_gen #(
  parameter int NUM_LANES = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sync_req_n,
  input wire logic [2:0] ilas_lane_sel,
  output jesd_link_pkg::link_state_t link_state,
  output logic ilas_cfg_valid,
  output logic [3:0] ilas_cfg_index,
  output logic [7:0] ilas_cfg_octet,
  output logic des_mode,
  output logic enc_64b66b,
  output logic [3:0] lanes_per_link,
  output logic [3:0] conv_per_link,
  output logic [3:0] octets_per_frame,
  output logic [3:0] samples_per_frame,
  output logic [4:0] sample_res,
  output logic [4:0] sample_bits,
  output logic [1:0] ctrl_bits,
  output logic high_density,
  output logic [8:0] frames_per_mf,
  output logic [7:0] mb_per_emb,
  output logic scrambler_en,
  output logic [5:0] pll_mult_x8,
  output logic pll_bypass
);
  import jesd_link_pkg::*;

  logic ctrl_en_r;
  logic ctrl_scr_r;
  logic [5:0] fmt_sel_r;
  logic [7:0] kcfg_r;
  logic [7:0] did_r;
  fmt_param_t der_p;
  fmt_param_t act_r;
  logic [8:0] k_req;
  logic [8:0] k_mask;
  logic [8:0] k_al;
  logic [8:0] k_use;
  logic k_bad;
  logic [8:0] k_act_r;
  logic k_bad_r;
  logic scr_act_r;
  logic [7:0] did_act_r;
  logic pll_bypass_r;
  logic sync_meta_r;
  logic sync_s_r;
  link_state_t state_r;
  link_state_t state_nxt;
  logic [8:0] fcnt_r;
  logic [2:0] mfcnt_r;
  logic ilas_last;
  logic cfg_slot;
  logic [7:0] base_sum;
  logic [4:0] lid_v [NUM_LANES];
  logic [7:0] sum_v [NUM_LANES];
  logic [7:0] octet_nxt;
  logic ilas_cfg_valid_r;
  logic [3:0] ilas_cfg_index_r;
  logic [7:0] ilas_cfg_octet_r;
  logic apb_acc;
  logic apb_wr;
  logic [31:0] rdata_nxt;
  logic rerr_nxt;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  // ****************************************
  // Format decode and frame count clamp
  // ****************************************
  fmt_table u_fmt_table (
    .fmt (fmt_sel_r),
    .p (der_p)
  );

  // frames per multiframe from user field
  assign k_req = {1'b0, kcfg_r} + 9'h001;
  assign k_mask = 9'((9'h001 << der_p.kstep_lg) - 9'h001);
  assign k_al = k_req & ~k_mask;
  // clamp down to step, up to minimum
  assign k_use = (k_al < {3'h0, der_p.kmin}) ? {3'h0, der_p.kmin} : k_al;
  assign k_bad = !der_p.enc64 && (k_use != k_req);

  // ****************************************
  // Active parameter snapshot
  // ****************************************
  // Loading only while off keeps a running link consistent
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      act_r <= '0;
      k_act_r <= 9'h000;
      k_bad_r <= 1'b0;
      scr_act_r <= 1'b0;
      did_act_r <= `DID_RESET;
      pll_bypass_r <= 1'b0;
    end else if (state_r == LINK_OFF) begin
      act_r <= der_p;
      k_act_r <= k_use;
      k_bad_r <= k_bad;
      scr_act_r <= ctrl_scr_r;
      did_act_r <= did_r;
      // PLL bypass from bits per clock
      pll_bypass_r <= (der_p.r_x8 == `PLL_BYPASS_R_X8);
    end
  end

  assign des_mode = act_r.des;
  assign enc_64b66b = act_r.enc64;
  assign lanes_per_link = act_r.l;
  assign conv_per_link = act_r.m;
  assign octets_per_frame = act_r.f;
  assign samples_per_frame = act_r.s;
  assign sample_res = act_r.n;
  assign sample_bits = act_r.np;
  assign ctrl_bits = act_r.cs;
  assign high_density = act_r.hd;
  assign frames_per_mf = k_act_r;
  assign mb_per_emb = `MB_PER_EMB;
  assign scrambler_en = scr_act_r;
  assign pll_mult_x8 = act_r.r_x8;
  assign pll_bypass = pll_bypass_r;

  // ****************************************
  // Sync request synchroniser
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync_meta_r <= 1'b1;
      sync_s_r <= 1'b1;
    end else begin
      sync_meta_r <= sync_req_n;
      sync_s_r <= sync_meta_r;
    end
  end

  // ****************************************
  // Link state machine
  // ****************************************
  assign ilas_last = (mfcnt_r == 3'(`ILAS_MF_COUNT - 3'h1)) && (fcnt_r == 9'(k_act_r - 9'h001));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      LINK_OFF: begin
        if (ctrl_en_r && der_p.valid) begin
          if (der_p.enc64) begin
            state_nxt = LINK_DATA;
          end else if (!sync_s_r) begin
            state_nxt = LINK_CGS;
          end
        end
      end
      LINK_CGS: begin
        if (!ctrl_en_r) begin
          state_nxt = LINK_OFF;
        end else if (sync_s_r) begin
          state_nxt = LINK_ILAS;
        end
      end
      LINK_ILAS: begin
        if (!ctrl_en_r) begin
          state_nxt = LINK_OFF;
        end else if (!sync_s_r) begin
          state_nxt = LINK_CGS;
        end else if (ilas_last) begin
          state_nxt = LINK_DATA;
        end
      end
      LINK_DATA: begin
        if (!ctrl_en_r) begin
          state_nxt = LINK_OFF;
        end else if (!act_r.enc64 && !sync_s_r) begin
          state_nxt = LINK_CGS;
        end
      end
      default: state_nxt = LINK_OFF;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= LINK_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign link_state = state_r;

  // One frame per clock during the alignment sequence
  always_ff @(posedge sys_clk) begin
    if (rst || state_r != LINK_ILAS || state_nxt != LINK_ILAS) begin
      fcnt_r <= 9'h000;
      mfcnt_r <= 3'h0;
    end else if (fcnt_r == 9'(k_act_r - 9'h001)) begin
      fcnt_r <= 9'h000;
      mfcnt_r <= 3'(mfcnt_r + 3'h1);
    end else begin
      fcnt_r <= 9'(fcnt_r + 9'h001);
    end
  end

  // ****************************************
  // Alignment checksum and octets
  // ****************************************
  // sum of fields, lane id added per lane
  assign base_sum = 8'(did_act_r + {7'h00, scr_act_r} + {4'h0, 4'(act_r.l - 4'h1)}
                       + {4'h0, 4'(act_r.f - 4'h1)} + 8'(k_act_r - 9'h001)
                       + {4'h0, 4'(act_r.m - 4'h1)} + {3'h0, 5'(act_r.n - 5'h01)}
                       + {5'h00, `SUBCLASSV_VAL} + {3'h0, 5'(act_r.np - 5'h01)}
                       + {5'h00, `JESDV_VAL} + {4'h0, 4'(act_r.s - 4'h1)});

  genvar gi;
  generate
    for (gi = 0; gi < NUM_LANES; gi++) begin : g_lane
      ilas_lane_sum #(
        .LANE_ID (gi)
      ) u_lane_sum (
        .base_sum (base_sum),
        .lane_id (lid_v[gi]),
        .lane_sum (sum_v[gi])
      );
    end
  endgenerate

  assign cfg_slot = (state_r == LINK_ILAS) && (mfcnt_r == 3'h1) && (fcnt_r < {5'h00, `ILAS_CFG_OCTETS});

  always_comb begin
    octet_nxt = 8'h00;
    // zero adjust, bank, control words, reserved
    case (fcnt_r[3:0])
      4'h0: octet_nxt = did_act_r;
      4'h2: octet_nxt = {3'h0, lid_v[ilas_lane_sel]};
      4'h3: octet_nxt = {scr_act_r, 2'h0, 5'(act_r.l - 4'h1)};
      4'h4: octet_nxt = {4'h0, 4'(act_r.f - 4'h1)};
      4'h5: octet_nxt = 8'(k_act_r - 9'h001);
      4'h6: octet_nxt = {4'h0, 4'(act_r.m - 4'h1)};
      4'h7: octet_nxt = {3'h0, 5'(act_r.n - 5'h01)};
      4'h8: octet_nxt = {`SUBCLASSV_VAL, 5'(act_r.np - 5'h01)};
      4'h9: octet_nxt = {`JESDV_VAL, 5'(act_r.s - 4'h1)};
      4'hd: octet_nxt = sum_v[ilas_lane_sel];
      default: octet_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ilas_cfg_valid_r <= 1'b0;
      ilas_cfg_index_r <= 4'h0;
      ilas_cfg_octet_r <= 8'h00;
    end else begin
      ilas_cfg_valid_r <= cfg_slot;
      ilas_cfg_index_r <= fcnt_r[3:0];
      ilas_cfg_octet_r <= cfg_slot ? octet_nxt : 8'h00;
    end
  end

  assign ilas_cfg_valid = ilas_cfg_valid_r;
  assign ilas_cfg_index = ilas_cfg_index_r;
  assign ilas_cfg_octet = ilas_cfg_octet_r;

  // ****************************************
  // APB slave
  // ****************************************
  // One wait state keeps read data registered
  assign apb_acc = psel && penable && !pready_r;
  assign apb_wr = psel && penable && pready_r && pwrite && !pslverr_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_en_r <= 1'b0;
      ctrl_scr_r <= 1'b0;
      fmt_sel_r <= `FMT_RESET;
      kcfg_r <= `KCFG_RESET;
      did_r <= `DID_RESET;
    end else if (apb_wr) begin
      case (paddr)
        `REG_CTRL: begin
          ctrl_en_r <= pwdata[`CTRL_EN_BIT];
          ctrl_scr_r <= pwdata[`CTRL_SCR_BIT];
          fmt_sel_r <= pwdata[`CTRL_FMT_MSB:`CTRL_FMT_LSB];
        end
        `REG_KCFG: kcfg_r <= pwdata[7:0];
        `REG_DID: did_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    rerr_nxt = 1'b0;
    if (paddr[1:0] == 2'h0 && paddr[7:5] == `LANE_SUM_PAGE && {2'h0, paddr[4:2]} < 5'(NUM_LANES)) begin
      rdata_nxt = {24'h00_0000, sum_v[paddr[4:2]]};
    end else begin
      case (paddr)
        `REG_CTRL: rdata_nxt = {18'h0_0000, fmt_sel_r, 6'h00, ctrl_scr_r, ctrl_en_r};
        `REG_KCFG: rdata_nxt = {24'h00_0000, kcfg_r};
        `REG_DID: rdata_nxt = {24'h00_0000, did_r};
        `REG_STATUS: rdata_nxt = {26'h000_0000, sync_s_r, act_r.enc64, k_bad_r, der_p.valid, state_r};
        `REG_PARAM_A: rdata_nxt = {act_r.hd, act_r.des, act_r.cs, 12'h000, act_r.s, act_r.f, act_r.m, act_r.l};
        `REG_PARAM_B: rdata_nxt = {1'b0, act_r.r_x8, act_r.np, act_r.n, 6'h00, k_act_r};
        default: rerr_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= apb_acc;
      pslverr_r <= apb_acc && rerr_nxt;
      prdata_r <= (apb_acc && !pwrite) ? rdata_nxt : 32'h0000_0000;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

endmodule : jesd_link_param_ilas_gen

// ---- verif/jesd_link_param_ilas_gen_properties.sv ----
// Port assertions for the link parameter block
`timescale 1ns/1ns
`include "jesd_link_cfg.svh"
module link_param_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input jesd_link_pkg::link_state_t link_state,
  input wire logic ilas_cfg_valid,
  input wire logic [3:0] ilas_cfg_index,
  input wire logic [7:0] ilas_cfg_octet,
  input wire logic enc_64b66b,
  input wire logic [8:0] frames_per_mf,
  input wire logic [7:0] mb_per_emb,
  input wire logic [5:0] pll_mult_x8,
  input wire logic pll_bypass
);
  import jesd_link_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // ********
  // Bus
  // ********
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_done;
    pready ##1 !pready;
  endsequence
  property p_apb_ans;
    s_wait |=> s_done;
  endproperty
  a_apb_ans: assert property (p_apb_ans) else $error("bus answer timing wrong");
  property p_err;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("error flag without ready or with data");
  // ********
  // Link
  // ********
  property p_emb;
    mb_per_emb == `MB_PER_EMB;
  endproperty
  a_emb: assert property (p_emb) else $error("multiblock count not one");
  property p_no64;
    enc_64b66b |-> !ilas_cfg_valid && link_state != LINK_ILAS;
  endproperty
  a_no64: assert property (p_no64) else $error("alignment sequence in 64b66b");
  property p_start;
    $rose(ilas_cfg_valid) |-> ilas_cfg_index == 4'h0 && link_state == LINK_ILAS;
  endproperty
  a_start: assert property (p_start) else $error("octets start wrong");
  property p_step;
    ilas_cfg_valid && ilas_cfg_index != 4'hd && frames_per_mf >= 9'd14
      |=> ilas_cfg_valid && ilas_cfg_index == $past(ilas_cfg_index) + 4'h1;
  endproperty
  a_step: assert property (p_step) else $error("octet index not consecutive");
  property p_zero;
    ilas_cfg_valid && ilas_cfg_index inside {4'h1, 4'ha, 4'hb, 4'hc} |-> ilas_cfg_octet == 8'h00;
  endproperty
  a_zero: assert property (p_zero) else $error("fixed zero octet wrong");
  property p_ver;
    ilas_cfg_valid && ilas_cfg_index inside {4'h7, 4'h8, 4'h9}
      |-> ilas_cfg_octet[7:5] == ((ilas_cfg_index == 4'h7) ? 3'h0 : `JESDV_VAL);
  endproperty
  a_ver: assert property (p_ver) else $error("version or control bits wrong");
  property p_kocts;
    ilas_cfg_valid && ilas_cfg_index == 4'h5 |-> ilas_cfg_octet == 8'(frames_per_mf - 9'h1);
  endproperty
  a_kocts: assert property (p_kocts) else $error("frame count octet wrong");
  property p_byp;
    pll_bypass == (pll_mult_x8 == `PLL_BYPASS_R_X8);
  endproperty
  a_byp: assert property (p_byp) else $error("bypass does not match factor");
endmodule : link_param_checker

bind jesd_link_param_ilas_gen link_param_checker u_chk (
  .sys_clk, .rst, .psel, .penable, .prdata, .pready, .pslverr, .link_state, .ilas_cfg_valid,
  .ilas_cfg_index, .ilas_cfg_octet, .enc_64b66b, .frames_per_mf, .mb_per_emb, .pll_mult_x8, .pll_bypass
);

// ---- verif/sync_rx_model.sv ----
// Receiver-side sync request model
`timescale 1ns/1ns
module sync_rx_model #(
  parameter int CGS_LEN = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic rx_en,
  input jesd_link_pkg::link_state_t link_state,
  output logic sync_req_n
);
  import jesd_link_pkg::*;
  logic [3:0] cgs_cnt_r;
  always_ff @(posedge sys_clk) begin
    if (rst || !rx_en) begin
      cgs_cnt_r <= 4'h0;
      sync_req_n <= 1'b1;
    end else if (link_state == LINK_OFF) begin
      cgs_cnt_r <= 4'h0;
      sync_req_n <= 1'b0;
    end else if (link_state == LINK_CGS) begin
      if (cgs_cnt_r == 4'(CGS_LEN)) begin
        sync_req_n <= 1'b1;
      end else begin
        cgs_cnt_r <= cgs_cnt_r + 4'h1;
      end
    end
  end
endmodule : sync_rx_model

// ---- verif/jesd_link_param_ilas_gen_tb.sv ----
// Self-checking bench for the link parameter block
`timescale 1ns/1ns
module jesd_link_param_ilas_gen_tb;
  import jesd_link_pkg::*;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, sync_req_n, rx_en, err;
  logic ilas_cfg_valid, des_mode, enc_64b66b, high_density, scrambler_en, pll_bypass;
  logic [7:0] paddr, ilas_cfg_octet, mb_per_emb;
  logic [31:0] pwdata, prdata, q;
  logic [2:0] ilas_lane_sel;
  link_state_t link_state;
  logic [3:0] ilas_cfg_index, lanes_per_link, conv_per_link, octets_per_frame, samples_per_frame;
  logic [4:0] sample_res, sample_bits;
  logic [1:0] ctrl_bits;
  logic [8:0] frames_per_mf;
  logic [5:0] pll_mult_x8;
  int mismatches, comparisons;
  logic [5:0] fmts [5] = '{6'h00, 6'h02, 6'h05, 6'h0d, 6'h13};
  logic [39:0] exp_p [5] = '{
    {3'h0, 1'b1, 4'h4, 4'h4, 4'h8, 4'h5, 5'h0c, 5'h0c, 2'h0, 1'b0, 6'h20, 1'b0},
    {3'h0, 1'b0, 4'h4, 4'h4, 4'h8, 4'h5, 5'h0c, 5'h0c, 2'h0, 1'b0, 6'h20, 1'b0},
    {3'h0, 1'b1, 4'h4, 4'h1, 4'h1, 4'h4, 5'h08, 5'h08, 2'h0, 1'b0, 6'h14, 1'b0},
    {3'h0, 1'b0, 4'h1, 4'h2, 4'h4, 4'h1, 5'h0f, 5'h10, 2'h1, 1'b0, 6'h28, 1'b1},
    {3'h0, 1'b1, 4'h6, 4'h1, 4'h2, 4'h8, 5'h0c, 5'h0c, 2'h0, 1'b1, 6'h14, 1'b0}};

  jesd_link_param_ilas_gen uut (
    .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sync_req_n, .ilas_lane_sel, .link_state, .ilas_cfg_valid, .ilas_cfg_index, .ilas_cfg_octet,
    .des_mode, .enc_64b66b, .lanes_per_link, .conv_per_link, .octets_per_frame, .samples_per_frame,
    .sample_res, .sample_bits, .ctrl_bits, .high_density, .frames_per_mf, .mb_per_emb,
    .scrambler_en, .pll_mult_x8, .pll_bypass
  );
  sync_rx_model rx (.sys_clk, .rst, .rx_en, .link_state, .sync_req_n);

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ********
  // Helpers
  // ********
  task automatic stop_test();
    if (mismatches == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Released on the completion edge, then one idle edge so the next setup never lands in the same step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      mismatches++;
      stop_test();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic wait_st(input link_state_t s, input int lim);
    int n;
    for (n = 0; n < lim && link_state !== s; n++) @(posedge sys_clk);
    chk("link_state", 40'(s), 40'(link_state));
    if (link_state !== s) stop_test();
  endtask : wait_st

  function automatic logic [39:0] pv();
    return {3'h0, des_mode, lanes_per_link, conv_per_link, octets_per_frame, samples_per_frame,
            sample_res, sample_bits, ctrl_bits, high_density, pll_mult_x8, pll_bypass};
  endfunction : pv

  // ********
  // Scenarios
  // ********
  task automatic t_reset();
    chk("params", exp_p[0], pv());
    chk("frames", 40'h20, 40'(frames_per_mf));
    chk("emb", 40'h1, 40'(mb_per_emb));
  endtask : t_reset

  task automatic t_apb();
    apb(1'b1, 8'h08, 32'h5a);
    apb(1'b0, 8'h08, 32'h0);
    chk("did", 40'h5a, 40'(q));
    apb(1'b0, 8'h04, 32'h0);
    chk("kcfg", 40'h1f, 40'(q));
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped", 40'h100000000, 40'({err, q}));
    apb(1'b1, 8'h10, 32'hffffffff);
    chk("ro_write", 40'h0, 40'(err));
  endtask : t_apb

  task automatic t_formats();
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 8'h00, {18'h0, fmts[i], 8'h00});
      // Snapshot loads one edge after the new code settles
      @(posedge sys_clk);
      chk("params", exp_p[i], pv());
    end
  endtask : t_formats

  task automatic t_clamp();
    logic [5:0] f [3] = '{6'h05, 6'h00, 6'h00};
    logic [7:0] kf [3] = '{8'h10, 8'h10, 8'hff};
    logic [9:0] ek [3] = '{10'h220, 10'h210, 10'h100};
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 8'h00, {18'h0, f[i], 8'h00});
      apb(1'b1, 8'h04, {24'h0, kf[i]});
      apb(1'b0, 8'h0c, 32'h0);
      chk("k_clamp", 40'(ek[i]), 40'({q[3], frames_per_mf}));
    end
  endtask : t_clamp

  task automatic t_64b();
    apb(1'b1, 8'h00, 32'h2001);
    wait_st(LINK_DATA, 8);
    chk("enc64", 40'h1, 40'(enc_64b66b));
    chk("emb", 40'h1, 40'(mb_per_emb));
    apb(1'b1, 8'h00, 32'h0);
    wait_st(LINK_OFF, 8);
  endtask : t_64b

  task automatic t_reserved();
    rx_en <= 1'b1;
    apb(1'b1, 8'h00, 32'h0401);
    repeat (8) @(posedge sys_clk);
    chk("reserved", 40'(LINK_OFF), 40'(link_state));
    apb(1'b1, 8'h00, 32'h0);
  endtask : t_reserved

  task automatic t_ilas();
    int n;
    logic [7:0] e [14];
    e = '{8'h5a, 8'h00, 8'h03, {1'b1, 2'h0, 5'd3}, 8'd7, 8'd15, 8'd3, {3'h0, 5'd11}, {3'h1, 5'd11},
          {3'h1, 5'd4}, 8'h00, 8'h00, 8'h00,
          8'h5a + 8'd1 + 8'd3 + 8'd7 + 8'd15 + 8'd3 + 8'd11 + 8'd11 + 8'd4 + 8'd1 + 8'd1 + 8'd3};
    ilas_lane_sel <= 3'h3;
    apb(1'b1, 8'h04, 32'h0f);
    apb(1'b1, 8'h00, 32'h3);
    wait_st(LINK_ILAS, 40);
    chk("scr", 40'h1, 40'(scrambler_en));
    for (n = 0; n < 40 && ilas_cfg_valid !== 1'b1; n++) @(posedge sys_clk);
    for (int i = 0; i < 14; i++) begin
      chk("octet", {27'h0, 1'b1, i[3:0], e[i]}, {27'h0, ilas_cfg_valid, ilas_cfg_index, ilas_cfg_octet});
      @(posedge sys_clk);
    end
    wait_st(LINK_DATA, 70);
    apb(1'b1, 8'h00, 32'h0201);
    chk("held_des", 40'h1, 40'(des_mode));
    apb(1'b1, 8'h00, 32'h0200);
    wait_st(LINK_OFF, 4);
    rx_en <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("des", 40'h0, 40'(des_mode));
  endtask : t_ilas

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ilas_lane_sel = 3'h0;
    rx_en = 1'b0;
    mismatches = 0;
    comparisons = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_apb();
    t_formats();
    t_clamp();
    t_64b();
    t_reserved();
    t_ilas();
    stop_test();
  end
endmodule : jesd_link_param_ilas_gen_tb
